// ==== design/dcf_fifo.v ====
// Programmable-flag FIFO: pin front end, flags, offset registers, output.
//
// Notes on behaviour
// (R1) A reset cycle is needed before use; it empties the FIFO, empty low.
// (R2) After reset releases, all nine data outputs are low.
// (R3) Outside party must pulse reset low and not access during it.
// (R4) Flags hold their reset values while reset is applied.
// (R5) Dual mode: write on write edge when primary low, secondary high.
// (R6) Both read enables low: next word shown at each read edge.
// (R7) Output enable low drives data outputs; high releases them.
// (R8) Writes while full are ignored; contents and pointer unchanged.
// (R9) Reads while empty ignored; outputs keep the last read word.
// (R10) Flag mode: primary enable alone qualifies writes, independent of reads.
// (R11) Dual pin high during reset: it becomes a second write enable.
// (R12) Dual pin low during reset: it becomes the offset load strobe.
// (R13) Load writes go empty-low, empty-high, full-low, full-high, then wrap.
// (R14) Raising load resumes normal use; sequence position is kept.
// (R15) Load reads follow the same cyclic order onto the data outputs.
// (R16) Outside party should not write and read offsets together.
// (R17) Almost-empty low when unread words at most n, high above.
// (R18) Almost-full low when unread words reach depth minus m.
// (R19) Both offsets default to seven after reset.
// (R20) Full updates on write edges, empty on read edges; they block.
// (R21) Depth is a power of two, 64 to 8192; unused offset bits zero.
`timescale 1ns/1ns
`include "dcf_consts.vh"
module dcf_fifo #(
    parameter [15:0] DEPTH = `DCF_DEPTH_DEFAULT
) (
    input wire clk_i,
    input wire rst_i,
    input wire write_clock_i,
    input wire read_clock_i,
    input wire fifo_reset_n_i,
    input wire write_enable_primary_n_i,
    input wire write_enable_secondary_or_load_i,
    input wire read_enable_a_n_i,
    input wire read_enable_b_n_i,
    input wire output_enable_n_i,
    input wire [`DCF_DATA_W-1:0] write_data_in_i,
    output wire [`DCF_DATA_W-1:0] read_data_out_o,
    output wire read_data_out_oe_o,
    output reg empty_flag_n_o,
    output reg full_flag_n_o,
    output reg almost_empty_flag_n_o,
    output reg almost_full_flag_n_o
);
    // R21 depth mask
    // Offsets only keep the bits that can address the array.
    localparam [15:0] OFF_MASK = DEPTH - 16'h0001;

    reg [`DCF_PIN_W-1:0] pin_s1;
    reg [`DCF_PIN_W-1:0] pin_s2;
    reg wclk_s3;
    reg rclk_s3;
    reg mode_dual;
    reg [1:0] seq;
    reg [15:0] empty_offset;
    reg [15:0] full_offset;
    reg [15:0] count;
    reg [`DCF_BYTE_W-1:0] offset_q;
    reg show_offset;
    wire wclk_rise;
    wire rclk_rise;
    wire fifo_rst;
    wire write_enable_primary_n_n;
    wire write_enable_secondary_or_load;
    wire load_active;
    wire ren_both;
    wire wr_go;
    wire rd_go;
    wire off_wr;
    wire off_rd;
    wire store_ready;
    wire store_valid;
    wire [`DCF_DATA_W-1:0] store_q;
    wire [`DCF_DATA_W-1:0] din;
    wire [15:0] next_count;
    reg [`DCF_BYTE_W-1:0] off_byte;

    // ======================================================================
    // Pin synchronisers
    // Every pin comes from outside this clock, so all pass two flops.
    // Data travels with the clock pins so a sampled edge sees its data.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1 <= {`DCF_PIN_W{1'b0}};
            pin_s2 <= {`DCF_PIN_W{1'b0}};
            wclk_s3 <= 1'b0;
            rclk_s3 <= 1'b0;
        end else begin
            pin_s1 <= {write_clock_i, read_clock_i, fifo_reset_n_i,
                       write_enable_primary_n_i,
                       write_enable_secondary_or_load_i,
                       read_enable_a_n_i, read_enable_b_n_i,
                       output_enable_n_i, write_data_in_i};
            pin_s2 <= pin_s1;
            wclk_s3 <= pin_s2[`DCF_PIN_WCLK];
            rclk_s3 <= pin_s2[`DCF_PIN_RCLK];
        end
    end

    // Rising edges of the sampled write and read clocks.
    assign wclk_rise = pin_s2[`DCF_PIN_WCLK] & ~wclk_s3;
    assign rclk_rise = pin_s2[`DCF_PIN_RCLK] & ~rclk_s3;
    assign write_enable_primary_n_n = pin_s2[`DCF_PIN_WRITE_ENABLE_PRIMARY_N_N];
    assign write_enable_secondary_or_load = pin_s2[`DCF_PIN_WRITE_ENABLE_SECONDARY_OR_LOAD];
    assign din = pin_s2[`DCF_DATA_W-1:0];

    // R1 R3 reset
    // The reset pin holds the store, offsets, count, flags and output select in their default state while low.
    assign fifo_rst = rst_i | ~pin_s2[`DCF_PIN_RST_N];

    // ======================================================================
    // Configuration captured at reset
    // R11 R12 capture
    // The last value of the dual pin seen while reset is low is kept.
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_dual <= `DCF_MODE_DUAL_RESET;
        end else if (~pin_s2[`DCF_PIN_RST_N]) begin
            mode_dual <= write_enable_secondary_or_load;
        end
    end

    // ======================================================================
    // Operation decode
    // R12 R14 load strobe
    // Load only exists in flag mode; raising it resumes normal traffic.
    assign load_active = ~mode_dual & ~write_enable_secondary_or_load;
    assign ren_both = ~pin_s2[`DCF_PIN_REN_A_N] & ~pin_s2[`DCF_PIN_REN_B_N];

    // R5 R10 R8 R20 write qualify
    // A stale full flag blocks writes until the next write edge updates it.
    assign wr_go = wclk_rise & ~fifo_rst & ~write_enable_primary_n_n & full_flag_n_o &
                   store_ready & (mode_dual ? write_enable_secondary_or_load : ~load_active);

    // R6 R9 R20 read qualify
    // Empty blocks reads; the output register then keeps its word.
    assign rd_go = rclk_rise & ~fifo_rst & ren_both & ~load_active &
                   empty_flag_n_o & store_valid;

    // R13 R15 offset access
    assign off_wr = wclk_rise & ~fifo_rst & ~write_enable_primary_n_n & load_active;
    assign off_rd = rclk_rise & ~fifo_rst & ren_both & load_active;

    // ======================================================================
    // Word store
    dcf_store #(
        .WIDTH(`DCF_DATA_W),
        .DEPTH(DEPTH)
    ) u_store (
        .clk_i(clk_i),
        .rst_i(fifo_rst),
        .in_valid_i(wr_go),
        .in_ready_o(store_ready),
        .in_data_i(din),
        .out_valid_o(store_valid),
        .out_ready_i(rd_go),
        .out_data_o(store_q)
    );

    // ======================================================================
    // Offset registers
    // R15 read mux
    always @* begin
        case (seq)
            `DCF_SEQ_EMPTY_LOW: off_byte = empty_offset[7:0];
            `DCF_SEQ_EMPTY_HIGH: off_byte = empty_offset[15:8];
            `DCF_SEQ_FULL_LOW: off_byte = full_offset[7:0];
            `DCF_SEQ_FULL_HIGH: off_byte = full_offset[15:8];
            default: off_byte = empty_offset[7:0];
        endcase
    end

    // R13 R14 R19 R21 offset writes
    // One position counter serves writes and reads, so mixing the two
    // moves it for both; that is why simultaneous use is discouraged.
    always @(posedge clk_i) begin
        if (fifo_rst) begin
            empty_offset <= `DCF_OFFSET_DEFAULT;
            full_offset <= `DCF_OFFSET_DEFAULT;
            seq <= `DCF_SEQ_EMPTY_LOW;
            offset_q <= {`DCF_BYTE_W{1'b0}};
        end else begin
            if (off_wr) begin
                case (seq)
                    `DCF_SEQ_EMPTY_LOW: begin
                        empty_offset <= {empty_offset[15:8], din[7:0]} &
                                        OFF_MASK;
                    end
                    `DCF_SEQ_EMPTY_HIGH: begin
                        empty_offset <= {din[7:0], empty_offset[7:0]} &
                                        OFF_MASK;
                    end
                    `DCF_SEQ_FULL_LOW: begin
                        full_offset <= {full_offset[15:8], din[7:0]} &
                                       OFF_MASK;
                    end
                    `DCF_SEQ_FULL_HIGH: begin
                        full_offset <= {din[7:0], full_offset[7:0]} &
                                       OFF_MASK;
                    end
                    default: begin
                        empty_offset <= empty_offset;
                    end
                endcase
            end
            if (off_rd) begin
                offset_q <= off_byte;
            end
            // Two-bit counter wraps from full-high back to empty-low.
            if (off_wr || off_rd) begin
                seq <= seq + 2'h1;
            end
        end
    end

    // ======================================================================
    // Output source
    // R2 R9 output select
    // Both sources reset to zero, so the outputs read low after reset.
    always @(posedge clk_i) begin
        if (fifo_rst) begin
            show_offset <= 1'b0;
        end else if (off_rd) begin
            show_offset <= 1'b1;
        end else if (rd_go) begin
            show_offset <= 1'b0;
        end
    end

    // Offset bytes leave bit 8 at zero.
    assign read_data_out_o = show_offset ? {1'b0, offset_q} : store_q;

    // R7 output enable
    assign read_data_out_oe_o = ~pin_s2[`DCF_PIN_OE_N];

    // ======================================================================
    // Word count and flags
    // The count is exact every cycle; the flags sample it only on their
    // own clock edge, which is what lets a stale flag block an access.
    assign next_count = count + {15'h0000, wr_go} - {15'h0000, rd_go};

    always @(posedge clk_i) begin
        if (fifo_rst) begin
            count <= 16'h0000;
        end else begin
            count <= next_count;
        end
    end

    // R4 R20 R18 write-side flags
    always @(posedge clk_i) begin
        if (fifo_rst) begin
            full_flag_n_o <= 1'b1;
            almost_full_flag_n_o <= 1'b1;
        end else if (wclk_rise) begin
            full_flag_n_o <= (next_count != DEPTH);
            almost_full_flag_n_o <= (next_count < (DEPTH - full_offset));
        end
    end

    // R1 R4 R20 R17 read-side flags
    always @(posedge clk_i) begin
        if (fifo_rst) begin
            empty_flag_n_o <= 1'b0;
            almost_empty_flag_n_o <= 1'b0;
        end else if (rclk_rise) begin
            empty_flag_n_o <= (next_count != 16'h0000);
            almost_empty_flag_n_o <= (next_count > empty_offset);
        end
    end
endmodule

// ==== design/dcf_store.v ====
// Word store for the FIFO: parameterised ring buffer with valid/ready.
`timescale 1ns/1ns
module dcf_store #(
    parameter WIDTH = 9,
    parameter DEPTH = 64
) (
    input wire clk_i,
    input wire rst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output reg [WIDTH-1:0] out_data_o
);
    localparam AW = $clog2(DEPTH);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wptr;
    reg [AW:0] rptr;

    // ======================================================================
    // Status
    // Extra pointer bit tells a full ring from an empty one.
    assign in_ready_o = ~((wptr[AW] != rptr[AW]) &&
                          (wptr[AW-1:0] == rptr[AW-1:0]));
    assign out_valid_o = (wptr != rptr);

    // ======================================================================
    // Array write, no reset so it maps onto block memory.
    always @(posedge clk_i) begin
        if (in_valid_i && in_ready_o) begin
            mem[wptr[AW-1:0]] <= in_data_i;
        end
    end

    // ======================================================================
    // Pointers and the registered read word.
    // The read word holds its value until the next pop; only reset clears it.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wptr <= {(AW+1){1'b0}};
            rptr <= {(AW+1){1'b0}};
            out_data_o <= {WIDTH{1'b0}};
        end else begin
            if (in_valid_i && in_ready_o) begin
                wptr <= wptr + {{AW{1'b0}}, 1'b1};
            end
            if (out_valid_o && out_ready_i) begin
                rptr <= rptr + {{AW{1'b0}}, 1'b1};
                out_data_o <= mem[rptr[AW-1:0]];
            end
        end
    end
endmodule

// ==== inc/dcf_consts.vh ====
// Constants for the programmable-flag FIFO block.
`ifndef DCF_CONSTS_VH
`define DCF_CONSTS_VH

// ==========================================================================
// Data path
`define DCF_DATA_W 9
`define DCF_BYTE_W 8

// ==========================================================================
// Offset register sequence positions (index of the next load access)
`define DCF_SEQ_EMPTY_LOW 2'h0
`define DCF_SEQ_EMPTY_HIGH 2'h1
`define DCF_SEQ_FULL_LOW 2'h2
`define DCF_SEQ_FULL_HIGH 2'h3

// ==========================================================================
// Reset values and the default depth
`define DCF_OFFSET_DEFAULT 16'h0007
`define DCF_DEPTH_DEFAULT 16'h0040
`define DCF_MODE_DUAL_RESET 1'h1

// ==========================================================================
// Bit positions inside the sampled pin vector
`define DCF_PIN_W 17
`define DCF_PIN_WCLK 16
`define DCF_PIN_RCLK 15
`define DCF_PIN_RST_N 14
`define DCF_PIN_WRITE_ENABLE_PRIMARY_N_N 13
`define DCF_PIN_WRITE_ENABLE_SECONDARY_OR_LOAD 12
`define DCF_PIN_REN_A_N 11
`define DCF_PIN_REN_B_N 10
`define DCF_PIN_OE_N 9

`endif

// ==== tb/dcf_fifo_monitor.sv ====
// Checker for the pin behaviour of the programmable-flag FIFO.
`timescale 1ns/1ns
`include "dcf_consts.vh"
module dcf_fifo_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire write_clock_i,
    input wire read_clock_i,
    input wire fifo_reset_n_i,
    input wire output_enable_n_i,
    input wire [`DCF_DATA_W-1:0] read_data_out_o,
    input wire read_data_out_oe_o,
    input wire empty_flag_n_o,
    input wire full_flag_n_o,
    input wire almost_empty_flag_n_o,
    input wire almost_full_flag_n_o
);
    reg [4:0] rc_h;
    reg [4:0] wc_h;
    reg [4:0] rn_h;
    reg [1:0] up;
    wire rd_near = |rc_h[4:1];
    wire wr_near = |wc_h[4:1];
    wire rs_near = ~&rn_h[4:1];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Pin history
    // Pins pass two sync stages, so an output may move only a few
    // cycles after the pin edge that caused it.
    always @(posedge clk_i) begin
        rc_h <= rst_i ? 5'h00 : {rc_h[3:0], read_clock_i};
        wc_h <= rst_i ? 5'h00 : {wc_h[3:0], write_clock_i};
        rn_h <= rst_i ? 5'h1F : {rn_h[3:0], fifo_reset_n_i};
        up <= rst_i ? 2'h0 : up + {1'b0, up != 2'h3};
    end
    // ==========================================================
    // Assertions
    chk_empty_edge: assert property (
        $changed(empty_flag_n_o) |-> rd_near || rs_near)
        else $error("empty flag moved off a read edge");
    chk_full_edge: assert property (
        $changed(full_flag_n_o) |-> wr_near || rs_near)
        else $error("full flag moved off a write edge");
    chk_afull_edge: assert property (
        $changed(almost_full_flag_n_o) |-> wr_near || rs_near)
        else $error("almost full moved off a write edge");
    chk_reset_flags: assert property (
        !fifo_reset_n_i [*4] |-> !empty_flag_n_o && full_flag_n_o
        && !almost_empty_flag_n_o && almost_full_flag_n_o)
        else $error("flags wrong during reset");
    chk_reset_data: assert property (
        !fifo_reset_n_i [*4] |-> read_data_out_o == 9'h000)
        else $error("data not low during reset");
    chk_empty_almost: assert property (
        !empty_flag_n_o |-> !almost_empty_flag_n_o)
        else $error("empty without almost empty");
    chk_data_edge: assert property (
        $changed(read_data_out_o) |-> rd_near || rs_near)
        else $error("data moved off a read edge");
    chk_oe_follow: assert property (
        up == 2'h3 && &rn_h |->
        read_data_out_oe_o == !$past(output_enable_n_i, 2))
        else $error("output enable does not follow pin");
    cover property (!full_flag_n_o);
    cover property ($rose(almost_empty_flag_n_o));
    cover property (!empty_flag_n_o ##1 empty_flag_n_o);
endmodule
bind dcf_fifo dcf_fifo_monitor u_dcf_fifo_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .write_clock_i(write_clock_i),
    .read_clock_i(read_clock_i), .fifo_reset_n_i(fifo_reset_n_i),
    .output_enable_n_i(output_enable_n_i),
    .read_data_out_o(read_data_out_o),
    .read_data_out_oe_o(read_data_out_oe_o),
    .empty_flag_n_o(empty_flag_n_o), .full_flag_n_o(full_flag_n_o),
    .almost_empty_flag_n_o(almost_empty_flag_n_o),
    .almost_full_flag_n_o(almost_full_flag_n_o)
);

// ==== tb/dcf_peer.sv ====
// Far-side model: producer and consumer pin clocks for the FIFO.
`timescale 1ns/1ns
module dcf_peer (
    input wire clk_i,
    input wire wr_go_i,
    input wire rd_go_i,
    output wire write_clock_o,
    output wire read_clock_o
);
    reg [3:0] wr_cnt = 4'h0;
    reg [3:0] rd_cnt = 4'h0;
    // ==========================================================
    // Pin clocks
    // A go strobe gives one period, four cycles high and four low, so the
    // sync stages see each edge; between strobes the clocks stand low.
    always @(posedge clk_i) begin
        wr_cnt <= wr_go_i ? 4'h8 : wr_cnt - {3'h0, wr_cnt != 4'h0};
        rd_cnt <= rd_go_i ? 4'h8 : rd_cnt - {3'h0, rd_cnt != 4'h0};
    end
    assign write_clock_o = wr_cnt > 4'h4;
    assign read_clock_o = rd_cnt > 4'h4;
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the programmable-flag FIFO.
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks = n_checks + 1; if ((a) !== (b)) begin \
    num_errors = num_errors + 1; \
    $display("mismatch %0t got %0h expected %0h", $time, (a), (b)); \
    end end
module testbench;
    localparam [15:0] DEPTH = 16'h0040;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg rs_n = 1'b0;
    reg wen_n = 1'b1;
    reg wen_ld = 1'b1;
    reg ra_n = 1'b1;
    reg rb_n = 1'b1;
    reg oe_n = 1'b0;
    reg [8:0] wdata = 9'h000;
    reg wr_go = 1'b0;
    reg rd_go = 1'b0;
    wire wclk, rclk, oe_o, ef_n, ff_n, ae_n, af_n;
    wire [8:0] rdata;
    integer seed = 62;
    integer num_errors = 0;
    integer n_checks = 0;
    integer rnd, i;
    // Offsets start at their defaults so early checks have a known value.
    integer n_off = 7;
    integer m_off = 7;
    reg [8:0] q[$];
    reg [8:0] last;
    // Expected flag levels, worked out from the word count and offsets.
    function exp_full_n(input integer c);
        begin
            exp_full_n = (c != DEPTH);
        end
    endfunction
    function exp_afull_n(input integer c, input integer m);
        begin
            exp_afull_n = (c < DEPTH - m);
        end
    endfunction
    function exp_aempty_n(input integer c, input integer n);
        begin
            exp_aempty_n = (c > n);
        end
    endfunction
    // The system clock toggles every half period.
    always #5 clk_i = ~clk_i;
    dcf_fifo #(.DEPTH(DEPTH)) u_dcf_fifo (.clk_i(clk_i), .rst_i(rst_i),
        .write_clock_i(wclk), .read_clock_i(rclk), .fifo_reset_n_i(rs_n),
        .write_enable_primary_n_i(wen_n),
        .write_enable_secondary_or_load_i(wen_ld),
        .read_enable_a_n_i(ra_n), .read_enable_b_n_i(rb_n),
        .output_enable_n_i(oe_n), .write_data_in_i(wdata),
        .read_data_out_o(rdata), .read_data_out_oe_o(oe_o),
        .empty_flag_n_o(ef_n), .full_flag_n_o(ff_n),
        .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n));
    dcf_peer u_dcf_peer (.clk_i(clk_i), .wr_go_i(wr_go), .rd_go_i(rd_go),
        .write_clock_o(wclk), .read_clock_o(rclk));
    // ==========================================================
    // Pin cycles
    // Inputs settle two cycles before the pin clock rises and hold past it.
    task cyc(input w, input r);
        begin
            @(posedge clk_i);
            wr_go <= w;
            rd_go <= r;
            @(posedge clk_i);
            wr_go <= 1'b0;
            rd_go <= 1'b0;
            repeat (10) @(posedge clk_i);
        end
    endtask
    task put(input [8:0] d, input s);
        begin
            wdata <= d;
            wen_n <= 1'b0;
            wen_ld <= s;
            cyc(1'b1, 1'b0);
            if (s && q.size() < DEPTH)
                q.push_back(d);
            `CHK(ff_n, exp_full_n(q.size()))
            `CHK(af_n, exp_afull_n(q.size(), m_off))
        end
    endtask
    task get(input a, input b);
        begin
            ra_n <= a;
            rb_n <= b;
            cyc(1'b0, 1'b1);
            if (!a && !b && q.size() != 0)
                last = q.pop_front();
            `CHK(rdata, last)
            `CHK(ef_n, q.size() != 0)
            `CHK(ae_n, exp_aempty_n(q.size(), n_off))
        end
    endtask
    task ldw(input [7:0] b);
        begin
            wdata <= {1'b0, b};
            wen_n <= 1'b0;
            cyc(1'b1, 1'b0);
        end
    endtask
    task ldr(input [7:0] b);
        begin
            ra_n <= 1'b0;
            rb_n <= 1'b0;
            cyc(1'b0, 1'b1);
            last = {1'b0, b};
            `CHK(rdata, last)
        end
    endtask
    task reset_fifo(input mode);
        begin
            rs_n <= 1'b0;
            wen_ld <= mode;
            wen_n <= 1'b1;
            ra_n <= 1'b1;
            rb_n <= 1'b1;
            repeat (6) @(posedge clk_i);
            `CHK(({ef_n, ff_n, ae_n, af_n}), 4'h5)
            rs_n <= 1'b1;
            repeat (6) @(posedge clk_i);
            last = 9'h000;
            `CHK(rdata, last)
            `CHK(oe_o, 1'b1)
            q.delete();
        end
    endtask
    task run(input integer n, input integer m);
        begin
            n_off = n;
            m_off = m;
            for (i = 0; i <= DEPTH; i = i + 1) begin
                rnd = $random(seed);
                put(rnd[8:0], 1'b1);
            end
            get(1'b1, 1'b0);
            get(1'b0, 1'b1);
            for (i = 0; i <= DEPTH; i = i + 1)
                get(1'b0, 1'b0);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d errors %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_fifo(1'b1);
        put(9'h1A5, 1'b0);
        run(7, 7);
        oe_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK(oe_o, 1'b0)
        oe_n <= 1'b0;
        reset_fifo(1'b0);
        ldw(8'h05);
        ldw(8'hFF);
        ldw(8'h09);
        ldw(8'h00);
        ldw(8'h03);
        wen_n <= 1'b1;
        wen_ld <= 1'b1;
        @(posedge clk_i);
        wen_ld <= 1'b0;
        ldr(8'h00);
        ldr(8'h09);
        ldr(8'h00);
        ldr(8'h03);
        wen_ld <= 1'b1;
        run(3, 9);
        end_of_test;
    end
    // A hang ends the run after well over the expected span.
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors = num_errors + 1;
        end_of_test;
    end
endmodule
